// >>> hdl/rwa_cfg.svh
/*
 * Constants of the receive word aligner and rate matcher: register
 * offsets, field positions, reset values and the fixed counts.
 * Assumes inclusion by bare name from every design file that needs them.
 */
`ifndef RWA_CFG_SVH
`define RWA_CFG_SVH

// register byte offsets on the apb side
`define RWA_OFS_CTRL 12'h000
`define RWA_OFS_PATTERN 12'h004
`define RWA_OFS_SYNC_CFG 12'h008
`define RWA_OFS_STATUS 12'h00C
`define RWA_OFS_INT_STAT 12'h010
`define RWA_OFS_INT_MASK 12'h014
`define RWA_OFS_RM_PAIR1 12'h018
`define RWA_OFS_RM_PAIR2 12'h01C

// control register fields
`define RWA_CTRL_AUTO 0
`define RWA_CTRL_PIPE 1
`define RWA_CTRL_BITREV 2
`define RWA_CTRL_RM_EN 3
`define RWA_CTRL_WIDE10 4
`define RWA_CTRL_RST 5'h10

// alignment pattern, low bits used for 10-bit words, 16 for 8-bit words
`define RWA_PATTERN_RST 16'h00FA

// sync config fields: acquire count in [3:0], lose count in [11:8]
`define RWA_SYNC_ACQ_LSB 0
`define RWA_SYNC_LOSE_LSB 8
`define RWA_SYNC_ACQ_RST 4'h3
`define RWA_SYNC_LOSE_RST 4'h4

// interrupt bit positions
`define RWA_INT_MATCH 0
`define RWA_INT_SYNC_UP 1
`define RWA_INT_SYNC_DOWN 2
`define RWA_INT_RM_INS 3
`define RWA_INT_RM_DEL 4
`define RWA_INT_RM_ERR 5
`define RWA_INT_W 6

// rate match pairs: control code in [9:0], skip code in [25:16]
`define RWA_RM_CTRL_LSB 0
`define RWA_RM_SKIP_LSB 16
`define RWA_K285_POS 10'h305
`define RWA_K285_NEG 10'h0FA
`define RWA_K297_POS 10'h117
`define RWA_K297_NEG 10'h2E8

// tolerated total offset and the fill marks that serve it
`define RWA_RM_PPM_TOTAL 200
`define RWA_RM_DEPTH 16
`define RWA_RM_HI_MARK 5'd12
`define RWA_RM_LO_MARK 5'd4

`endif

// >>> hdl/rwa_pkg.sv
/*
 * Types shared by the word aligner and its rate matcher.
 * Assumes the constants header is compiled alongside.
 */
package rwa_pkg;
    // synchronisation states, one-hot
    typedef enum logic [2:0] {
        RWA_LOSS = 3'b001,
        RWA_ACQ = 3'b010,
        RWA_SYNC = 3'b100
    } rwa_sync_e;

    typedef logic [9:0] rwa_word_t;
endpackage

// >>> hdl/rwa_rate_match.sv
/*
 * Rate-match fifo: drops a skip on the write side when filling up and
 * repeats one on the read side when running dry, once per cluster.
 * Assumes writer and reader share mclk; the reader's request models the
 * local clock rate.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rwa_cfg.svh"
module rwa_rate_match import rwa_pkg::*; #(
    parameter int DEPTH = `RWA_RM_DEPTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    // control
    input wire logic enable,
    input wire logic [9:0] ctrl1,
    input wire logic [9:0] skip1,
    input wire logic [9:0] ctrl2,
    input wire logic [9:0] skip2,
    // write side
    input wire logic wr_en,
    input wire logic [9:0] wr_data,
    // read side
    input wire logic rd_req,
    output logic [9:0] rd_data,
    output logic rd_valid,
    // events
    output logic ins_pulse,
    output logic del_pulse,
    output logic err_pulse
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 8 || (1 << AW) != DEPTH)
            $error("rate match depth must be a power of two, at least 8");
    end

    rwa_word_t mem [DEPTH];
    logic [AW-1:0] wp, rp;
    logic [AW:0] count;
    logic [1:0] wr_prev_ctrl, rd_prev_ctrl;
    logic wr_done, rd_done;
    logic [1:0] wr_is_ctrl, wr_is_skip, rd_is_ctrl, rd_is_skip;
    logic do_del, do_wr, can_rd, do_ins, do_rd;
    rwa_word_t head;

    assign head = mem[rp];
    assign wr_is_ctrl = {wr_data == ctrl2, wr_data == ctrl1};
    assign wr_is_skip = {wr_data == skip2, wr_data == skip1};
    assign rd_is_ctrl = {head == ctrl2, head == ctrl1};
    assign rd_is_skip = {head == skip2, head == skip1};
    // skip right behind its own control code, cluster not yet touched
    assign do_del = wr_en && |(wr_is_skip & wr_prev_ctrl) && !wr_done // RULE13 RULE14
        && count > (AW+1)'(`RWA_RM_HI_MARK);
    assign can_rd = enable && rd_req && count != '0;
    assign do_ins = can_rd && |(rd_is_skip & rd_prev_ctrl) && !rd_done // RULE13 RULE14
        && count < (AW+1)'(`RWA_RM_LO_MARK);
    assign do_wr = enable && wr_en && !do_del && count != (AW+1)'(DEPTH);
    // an inserted skip leaves the head in place so it is read again
    assign do_rd = can_rd && !do_ins;

    // storage and pointers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wp <= '0;
            rp <= '0;
            count <= '0;
        end else if (ce) begin
            if (!enable) begin
                wp <= '0;
                rp <= '0;
                count <= '0;
            end else begin
                if (do_wr) begin
                    mem[wp] <= wr_data;
                    wp <= wp + 1'b1;
                end
                if (do_rd)
                    rp <= rp + 1'b1;
                count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
            end
        end
    end

    // cluster tracking, write and read sides apart
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_prev_ctrl <= 2'h0;
            rd_prev_ctrl <= 2'h0;
            wr_done <= 1'b0;
            rd_done <= 1'b0;
        end else if (ce) begin
            if (wr_en) begin
                wr_prev_ctrl <= wr_is_ctrl;
                if (do_del)
                    wr_done <= 1'b1;
                else if (!(|wr_is_ctrl) && !(|wr_is_skip))
                    wr_done <= 1'b0;
            end
            if (can_rd) begin
                rd_prev_ctrl <= do_ins ? rd_prev_ctrl : rd_is_ctrl;
                if (do_ins)
                    rd_done <= 1'b1;
                else if (!(|rd_is_ctrl) && !(|rd_is_skip))
                    rd_done <= 1'b0;
            end
        end
    end

    // registered read port and events
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= 10'h000;
            rd_valid <= 1'b0;
            ins_pulse <= 1'b0;
            del_pulse <= 1'b0;
            err_pulse <= 1'b0;
        end else if (ce) begin
            rd_valid <= can_rd;
            if (can_rd)
                rd_data <= head;
            ins_pulse <= do_ins;
            del_pulse <= enable && do_del;
            // overflow or underrun despite the skips
            err_pulse <= enable && ((wr_en && !do_del && !do_wr) || (rd_req && !can_rd));
        end
    end
endmodule
`default_nettype wire

// >>> hdl/rwa_sync2.sv
/*
 * Two-flop level synchroniser, W bits wide.
 * Assumes each bit is an independent slow level from outside mclk.
 */
`timescale 1ns/100ps
`default_nettype none
module rwa_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    // levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= '0;
            q <= '0;
        end else if (ce) begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/rwa_top.sv
/*
 * Receive word aligner with bit-slip and automatic sync modes, polarity
 * inversion, bit reversal, decoder-input inversion and a rate matcher,
 * all behind an apb register file with one level interrupt.
 * Assumes parallel words arrive on mclk from the deserializer every cycle;
 * the slip request and both invert controls are pins from outside.
 */
// Decided for this implementation: the register offsets and the APB slave port.
// How it works
// (RULE1) each rising slip-request edge moves the word boundary by one bit
// (RULE2) the slipped bit enters at the msb, contents move toward the lsb
// (RULE3) a pattern match raises the match flag for one cycle
// (RULE4) 8-bit words match a 16-bit pattern over two words, earlier first
// (RULE5) fabric slips until the match flag or the data show alignment
// (RULE6) auto mode syncs after N commas, loses sync after M bad groups
// (RULE7) auto mode only works with 10-bit 8b10b words
// (RULE8) polarity invert complements the aligner input, changeable at any time
// (RULE9) aligner-input invert is off in pipe mode, decoder invert only there
// (RULE10) downstream tolerates disparity errors from a polarity change
// (RULE11) lsb-first by default, optional reversal of the word's bit order
// (RULE12) the rate matcher runs only once the link is synchronised
// (RULE13) a skip behind its control code is inserted or dropped as needed
// (RULE14) at most one skip inserted or dropped per cluster
// (RULE15) default pairs are positive and negative K28.5 with K29.7
// (RULE16) fifo depth absorbs plus or minus 100 ppm
// (RULE17) system keeps frequency offset under 200 ppm
// (RULE18) in pipe mode decoder invert complements all ten decoder bits
// (RULE19) slip request is synchronised and edge detected on mclk
`timescale 1ns/100ps
`default_nettype none
`include "rwa_cfg.svh"
module rwa_top import rwa_pkg::*; #(
    parameter int RM_DEPTH = `RWA_RM_DEPTH
) (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // deserializer side
    input wire logic [9:0] rx_par_in,
    input wire logic rx_slip_req,
    input wire logic rx_pol_invert,
    input wire logic decoder_input_invert,
    // fabric side
    output logic [9:0] rx_word_out,
    output logic [9:0] dec_word_out,
    output logic align_match,
    output logic link_sync,
    input wire logic rm_rd_req,
    output logic [9:0] rm_data,
    output logic rm_valid,
    output logic irq
);
    // registers
    logic [4:0] ctrl;
    logic [15:0] pattern;
    logic [3:0] acq_cnt_cfg, lose_cnt_cfg;
    logic [`RWA_INT_W-1:0] int_stat, int_mask, int_evt;
    logic [25:0] rm_pair1, rm_pair2;

    // pins into mclk
    logic [2:0] pins_q;
    logic slip_q, slip_d, pol_q, dinv_q;
    logic slip_edge;

    // datapath
    rwa_word_t cur_in, prev_in, aligned, aligned_prev, reversed;
    logic [19:0] window;
    logic [3:0] offset;
    logic wide10, auto_on, pipe_on, match_now;
    logic [9:0] pol_mask, dinv_mask;
    logic hit_any;
    logic [3:0] hit_off;
    logic code_err;

    // sync machine
    rwa_sync_e state, next_state;
    logic [3:0] good_cnt, bad_cnt;
    logic manual_sync, sync_now;
    logic sync_was;
    logic rm_ins, rm_del, rm_err;

    // apb decode
    logic wr_hit, setup;
    logic [31:0] next_rdata;
    logic next_err;

    assign wide10 = ctrl[`RWA_CTRL_WIDE10];
    assign auto_on = ctrl[`RWA_CTRL_AUTO] && wide10; // RULE7
    assign pipe_on = ctrl[`RWA_CTRL_PIPE];

    rwa_sync2 #(
        .W(3)
    ) u_pins (
        .mclk(mclk),
        .rst_b(rst_b),
        .ce(ce),
        .d({decoder_input_invert, rx_pol_invert, rx_slip_req}),
        .q(pins_q)
    );
    assign slip_q = pins_q[0];
    assign pol_q = pins_q[1];
    assign dinv_q = pins_q[2];

    // edge detect behind the synchroniser, so one edge is one slip
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            slip_d <= 1'b0;
        else if (ce)
            slip_d <= slip_q;
    end
    assign slip_edge = slip_q && !slip_d; // RULE19

    // polarity is applied before the aligner and never in pipe mode
    assign pol_mask = {10{pol_q && !pipe_on}}; // RULE8 RULE9

    // two-word history the aligner picks its window from
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cur_in <= 10'h000;
            prev_in <= 10'h000;
        end else if (ce) begin
            cur_in <= rx_par_in ^ pol_mask; // RULE8
            prev_in <= cur_in;
        end
    end

    // newer word above the older one; a larger offset pulls newer bits in at the msb
    assign window = wide10 ? {cur_in, prev_in} : {4'h0, cur_in[7:0], prev_in[7:0]};
    always_comb begin
        logic [19:0] sh;
        sh = window >> offset; // RULE2
        aligned = wide10 ? sh[9:0] : {2'b00, sh[7:0]};
    end

    // comma search over all offsets, lowest offset wins
    always_comb begin
        logic [19:0] sh;
        sh = 20'h00000;
        hit_any = 1'b0;
        hit_off = 4'h0;
        for (int o = 9; o >= 0; o--) begin
            sh = window >> o;
            if (sh[9:0] == pattern[9:0]) begin
                hit_any = 1'b1;
                hit_off = 4'(o);
            end
        end
    end

    // word disparity check stands in for a decoder error
    always_comb begin
        logic [3:0] ones;
        ones = 4'h0;
        for (int i = 0; i < 10; i++)
            ones = ones + 4'(aligned[i]);
        code_err = ones < 4'd4 || ones > 4'd6;
    end

    // 8-bit words: earlier word in the low half of the pattern
    assign match_now = wide10 ? (aligned == pattern[9:0]) // RULE3
        : ({aligned[7:0], aligned_prev[7:0]} == pattern); // RULE4

    // word boundary: slips by hand, or relocks on a comma when unsynced
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            offset <= 4'h0;
        else if (ce) begin
            if (auto_on) begin
                if (state == RWA_LOSS && hit_any)
                    offset <= hit_off;
            end else if (slip_edge) begin // RULE1
                offset <= (offset == (wide10 ? 4'd9 : 4'd7)) ? 4'h0 : offset + 4'd1;
            end
        end
    end

    // sync state, hysteresis through two counters
    always_comb begin
        next_state = state;
        unique case (state)
            RWA_LOSS: begin
                if (hit_any)
                    next_state = RWA_ACQ;
            end
            RWA_ACQ: begin
                if (code_err)
                    next_state = RWA_LOSS;
                else if (match_now && good_cnt + 4'd1 >= acq_cnt_cfg)
                    next_state = RWA_SYNC; // RULE6
            end
            RWA_SYNC: begin
                if (code_err && bad_cnt + 4'd1 >= lose_cnt_cfg)
                    next_state = RWA_LOSS; // RULE6
            end
        endcase
        if (!auto_on)
            next_state = RWA_LOSS;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= RWA_LOSS;
            good_cnt <= 4'h0;
            bad_cnt <= 4'h0;
        end else if (ce) begin
            state <= next_state;
            // one comma counted on entry to acquire
            good_cnt <= (next_state != RWA_ACQ) ? 4'h0
                : (state == RWA_LOSS) ? 4'h1 : good_cnt + 4'(match_now);
            // only consecutive bad groups count toward losing sync
            bad_cnt <= (state == RWA_SYNC && code_err) ? bad_cnt + 4'd1 : 4'h0;
        end
    end

    // bit-slip mode: synced from a match until the next slip
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            manual_sync <= 1'b0;
        else if (ce) begin
            if (auto_on || slip_edge)
                manual_sync <= 1'b0;
            else if (match_now)
                manual_sync <= 1'b1;
        end
    end
    assign sync_now = auto_on ? (state == RWA_SYNC) : manual_sync;

    // bit order reversal across the active width
    always_comb begin
        reversed = 10'h000;
        for (int i = 0; i < 10; i++) begin
            if (wide10)
                reversed[i] = aligned[9-i];
            else if (i < 8)
                reversed[i] = aligned[7-i];
        end
    end

    // registered outputs toward the fabric and the decoder
    assign dinv_mask = {10{dinv_q && pipe_on}}; // RULE9
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            aligned_prev <= 10'h000;
            rx_word_out <= 10'h000;
            dec_word_out <= 10'h000;
            align_match <= 1'b0;
            link_sync <= 1'b0;
            sync_was <= 1'b0;
        end else if (ce) begin
            aligned_prev <= aligned;
            rx_word_out <= ctrl[`RWA_CTRL_BITREV] ? reversed : aligned; // RULE11
            dec_word_out <= aligned ^ dinv_mask; // RULE18
            align_match <= match_now; // RULE3
            link_sync <= sync_now;
            sync_was <= sync_now;
        end
    end

    // fifo only fills once synced; depth covers the offset
    rwa_rate_match #(
        .DEPTH(RM_DEPTH) // RULE16
    ) u_rm (
        .mclk(mclk),
        .rst_b(rst_b),
        .ce(ce),
        .enable(ctrl[`RWA_CTRL_RM_EN] && link_sync), // RULE12
        .ctrl1(rm_pair1[`RWA_RM_CTRL_LSB +: 10]),
        .skip1(rm_pair1[`RWA_RM_SKIP_LSB +: 10]),
        .ctrl2(rm_pair2[`RWA_RM_CTRL_LSB +: 10]),
        .skip2(rm_pair2[`RWA_RM_SKIP_LSB +: 10]),
        .wr_en(link_sync),
        .wr_data(rx_word_out),
        .rd_req(rm_rd_req),
        .rd_data(rm_data),
        .rd_valid(rm_valid),
        .ins_pulse(rm_ins),
        .del_pulse(rm_del),
        .err_pulse(rm_err)
    );

    // apb: setup cycle decodes, access cycle answers with no wait
    assign setup = psel && !penable;
    assign wr_hit = psel && penable && pready && pwrite;
    always_comb begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        unique case (paddr)
            `RWA_OFS_CTRL: next_rdata = {27'h0, ctrl};
            `RWA_OFS_PATTERN: next_rdata = {16'h0, pattern};
            `RWA_OFS_SYNC_CFG: next_rdata = {20'h0, lose_cnt_cfg, 4'h0, acq_cnt_cfg};
            `RWA_OFS_STATUS: next_rdata = {22'h0, offset, 3'h0, state == RWA_ACQ, manual_sync,
                link_sync};
            `RWA_OFS_INT_STAT: next_rdata = {26'h0, int_stat};
            `RWA_OFS_INT_MASK: next_rdata = {26'h0, int_mask};
            `RWA_OFS_RM_PAIR1: next_rdata = {6'h0, rm_pair1};
            `RWA_OFS_RM_PAIR2: next_rdata = {6'h0, rm_pair2};
            default: next_err = 1'b1;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= setup;
            if (setup) begin
                prdata <= pwrite ? 32'h00000000 : next_rdata;
                pslverr <= next_err;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // writable configuration
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= `RWA_CTRL_RST;
            pattern <= `RWA_PATTERN_RST;
            acq_cnt_cfg <= `RWA_SYNC_ACQ_RST;
            lose_cnt_cfg <= `RWA_SYNC_LOSE_RST;
            int_mask <= '0;
            rm_pair1 <= {`RWA_K297_POS, 6'h0, `RWA_K285_POS}; // RULE15
            rm_pair2 <= {`RWA_K297_NEG, 6'h0, `RWA_K285_NEG}; // RULE15
        end else if (ce && wr_hit) begin
            unique case (paddr)
                `RWA_OFS_CTRL: ctrl <= pwdata[4:0];
                `RWA_OFS_PATTERN: pattern <= pwdata[15:0];
                `RWA_OFS_SYNC_CFG: begin
                    acq_cnt_cfg <= pwdata[`RWA_SYNC_ACQ_LSB +: 4];
                    lose_cnt_cfg <= pwdata[`RWA_SYNC_LOSE_LSB +: 4];
                end
                `RWA_OFS_INT_MASK: int_mask <= pwdata[`RWA_INT_W-1:0];
                `RWA_OFS_RM_PAIR1: rm_pair1 <= {pwdata[25:16], 6'h0, pwdata[9:0]};
                `RWA_OFS_RM_PAIR2: rm_pair2 <= {pwdata[25:16], 6'h0, pwdata[9:0]};
                default: ;
            endcase
        end
    end

    // sticky events, write one to clear; a new event beats the clear
    assign int_evt = {rm_err, rm_del, rm_ins, sync_was && !sync_now, !sync_was && sync_now,
        match_now};
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            int_stat <= '0;
        else if (ce) begin
            if (wr_hit && paddr == `RWA_OFS_INT_STAT)
                int_stat <= (int_stat & ~pwdata[`RWA_INT_W-1:0]) | int_evt;
            else
                int_stat <= int_stat | int_evt;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            irq <= 1'b0;
        else if (ce)
            irq <= |(int_stat & int_mask);
    end
endmodule
`default_nettype wire

// >>> verif/rwa_assertions.sv
/* port timing checker for rwa_top: apb handshake and rate matcher gating.
   assumes a bind from the bench top, one clock domain */
`timescale 1ns/100ps
`default_nettype none
module rwa_chk (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // fabric
    input wire logic link_sync,
    input wire logic rm_rd_req,
    input wire logic rm_valid
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // apb setup phase, and a link that stayed down
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence down_s;
        !link_sync [*3];
    endsequence
    setup_ready_a: assert property (setup_s |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    mapped_ok_a: assert property (pready && paddr <= 12'h01C |-> !pslverr)
        else $error("mapped access refused");
    rm_gate_a: assert property (down_s |=> !rm_valid)
        else $error("rate matcher output without sync");
    rm_answer_a: assert property (rm_valid |-> $past(rm_rd_req))
        else $error("read served without request");
endmodule
`default_nettype wire

// >>> verif/rwa_fabric.sv
/* far side: deserializer repeating one word, and a fabric slip controller.
   assumes the bench sets word and hunt */
`timescale 1ns/100ps
`default_nettype none
module rwa_fabric (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // bench control
    input wire logic [9:0] word,
    input wire logic hunt,
    // aligner side
    input wire logic align_match,
    output logic [9:0] rx_par_in,
    output logic rx_slip_req,
    output logic [3:0] slips
);
    logic [3:0] phase;
    // slip every ten cycles until a match; 4 high, 6 low so edges never merge
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= 4'h0;
            rx_slip_req <= 1'b0;
            slips <= 4'h0;
            rx_par_in <= 10'h000;
        end else begin
            rx_par_in <= word;
            if (!hunt || align_match) begin
                phase <= 4'h0;
                rx_slip_req <= 1'b0;
            end else begin
                phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
                rx_slip_req <= (phase < 4'h4);
                slips <= slips + {3'h0, phase == 4'h0};
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/test_rx_word_align_rate_match.sv
/* bench for rwa_top: apb tasks, fabric model, checker bound in.
   assumes design, model and checker compile first */
`timescale 1ns/100ps
`default_nettype none
module test_rx_word_align_rate_match;
    logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, e, hunt;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic rx_slip_req, rx_pol_invert, decoder_input_invert, align_match;
    logic link_sync, rm_rd_req, rm_valid, irq;
    logic [9:0] word, rx_par_in, rx_word_out, dec_word_out, rm_data;
    logic [3:0] slips;
    int mismatches, n_checks, ncyc;
    rwa_top u_rwa_top (.mclk, .rst_b, .ce(1'b1), .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_par_in, .rx_slip_req,
        .rx_pol_invert, .decoder_input_invert, .rx_word_out, .dec_word_out,
        .align_match, .link_sync, .rm_rd_req, .rm_data, .rm_valid, .irq);
    rwa_fabric u_rwa_fabric (.mclk, .rst_b, .word, .hunt, .align_match,
        .rx_par_in, .rx_slip_req, .slips);
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] x);
        n_checks++;
        if (got !== x) begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, got, x);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // clock, 40 ns period
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // hang guard, far above the test length
    always @(posedge mclk) begin
        ncyc++;
        if (ncyc == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end
    // stream word 0x3D1 lines up with the 0x0FA pattern after three slips
    initial begin
        {rst_b, psel, penable, pwrite, hunt, rm_rd_req} = 6'h0;
        {rx_pol_invert, decoder_input_invert, paddr, pwdata} = 'h0;
        word = 10'h3D1;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        cyc(2);
        rd(12'h000, 32'h10);
        rd(12'h018, 32'h01170305);
        rd(12'h01C, 32'h02E800FA);
        rd(12'h020, 32'h0);
        chk(e, 1'b1);
        $display("test registers done");
        hunt <= 1'b1;
        cyc(60);
        chk(slips, 4'h3);
        chk(rx_word_out, 10'h0FA);
        chk(align_match, 1'b1);
        chk(link_sync, 1'b1);
        hunt <= 1'b0;
        apb(1'b1, 12'h004, 32'h3A3A);
        apb(1'b1, 12'h000, 32'h0);
        cyc(8);
        chk(align_match, 1'b1);
        chk(rx_word_out[7:0], 8'h3A);
        apb(1'b1, 12'h004, 32'h003A);
        cyc(8);
        chk(align_match, 1'b0);
        apb(1'b1, 12'h004, 32'h00FA);
        apb(1'b1, 12'h000, 32'h10);
        $display("test slip done");
        rx_pol_invert <= 1'b1;
        cyc(8);
        chk(rx_word_out, 10'h305);
        apb(1'b1, 12'h000, 32'h12);
        cyc(8);
        chk(rx_word_out, 10'h0FA);
        decoder_input_invert <= 1'b1;
        cyc(8);
        chk(dec_word_out, 10'h305);
        rx_pol_invert <= 1'b0;
        apb(1'b1, 12'h000, 32'h10);
        cyc(8);
        chk(dec_word_out, 10'h0FA);
        decoder_input_invert <= 1'b0;
        apb(1'b1, 12'h000, 32'h14);
        cyc(8);
        chk(rx_word_out, 10'h17C);
        $display("test invert done");
        apb(1'b1, 12'h000, 32'h18);
        rm_rd_req <= 1'b1;
        cyc(10);
        chk(rm_valid, 1'b1);
        chk(rm_data, 10'h0FA);
        rm_rd_req <= 1'b0;
        $display("test rate match done");
        word <= 10'h000;
        cyc(8);
        apb(1'b1, 12'h014, 32'h1);
        cyc(3);
        chk(irq, 1'b1);
        apb(1'b1, 12'h010, 32'h1);
        cyc(3);
        chk(irq, 1'b0);
        $display("test interrupt done");
        word <= 10'h3D1;
        apb(1'b1, 12'h000, 32'h01);
        cyc(40);
        chk(link_sync, 1'b1);
        apb(1'b1, 12'h000, 32'h11);
        cyc(40);
        chk(link_sync, 1'b1);
        word <= 10'h3FF;
        cyc(20);
        chk(link_sync, 1'b0);
        $display("test auto sync done");
        report_and_stop();
    end
endmodule
bind rwa_top rwa_chk u_rwa_chk (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_sync(link_sync),
    .rm_rd_req(rm_rd_req), .rm_valid(rm_valid));
`default_nettype wire
